// file: rtl/mne_pkg.sv
`default_nettype none
package mne_pkg;

  // Sample and accumulator widths
  localparam int SAMPLE_W    = 16;
  localparam int DEV_W       = 18;
  localparam int ACC_W       = 32;
  localparam int WIN_W       = 36;
  localparam int NOISE_W     = 25;
  localparam int TC_W        = 4;
  localparam int SETTLE_W    = 20;

  // Estimator window: 16 blocks of T samples each, i.e. 16 time constants
  localparam int BLOCKS      = 16;
  localparam int BLOCKS_LOG2 = 4;
  localparam int FIFO_W      = 4 * ACC_W;

  // Sample rate; time constant T = 2**tcSel samples of this rate
  localparam int SAMPLE_RATE_HZ = 512;

  // Slope selector codes
  localparam logic [1:0] SLOPE_6DB  = 2'h0;
  localparam logic [1:0] SLOPE_12DB = 2'h1;
  localparam logic [1:0] SLOPE_18DB = 2'h2;
  localparam logic [1:0] SLOPE_24DB = 2'h3;

  // Noise bandwidth = NUM / (DEN * T), indexed by slope
  localparam logic [3:0][2:0] NOISE_BW_NUM = {3'h5, 3'h3, 3'h1, 3'h1};
  localparam logic [3:0][6:0] NOISE_BW_DEN = {7'h40, 7'h20, 7'h08, 7'h04};

  // 99 % settling time in units of T, indexed by slope
  localparam logic [3:0][3:0] WAIT_MULT = {4'ha, 4'h9, 4'h7, 4'h5};

  // Q0.16 gain: 1.2533 * sqrt(1/(NUM/DEN)) / sqrt(512), even and odd tc codes
  localparam int          K_FRAC     = 16;
  localparam logic [3:0][15:0] RMS_K_EVEN = {16'h32bb, 16'h2e50, 16'h281a, 16'h1c5c};
  localparam logic [3:0][15:0] RMS_K_ODD  = {16'h23e0, 16'h20bf, 16'h1c5b, 16'h140e};

  typedef enum {MNE_IDLE, MNE_DRAIN, MNE_LOAD} mne_state_t;

endpackage
`default_nettype wire

// file: rtl/mne_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mne_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] inData;
  logic         inValid;
  logic         inReady;
  logic [W-1:0] outData;
  logic         outValid;
  logic         outReady;
  logic         flush;
  logic         full;

  modport fifo (
    input  inData, inValid, outReady, flush,
    output inReady, outData, outValid, full
  );
  modport user (
    output inData, inValid, outReady, flush,
    input  inReady, outData, outValid, full
  );
endinterface
`default_nettype wire

// file: rtl/mne_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module mne_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic   clk,
  input wire logic   rst_n,
  mne_stream_if.fifo s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [WIDTH-1:0] outData_reg;
  wire [AW-1:0]     rdPtrNext;
  wire              push;
  wire              pop;

  assign s.full     = (count_reg == DEPTH[AW:0]);
  assign s.inReady  = !s.full;
  assign s.outValid = (count_reg != '0);
  assign s.outData  = outData_reg;
  assign rdPtrNext  = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
  assign push       = s.inValid && s.inReady;
  assign pop        = s.outValid && s.outReady;

  always_ff @(posedge clk) begin
    if (!rst_n || s.flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= s.inData;
    end
  end

  // Head word registered; a push into the head slot bypasses the array
  always_ff @(posedge clk) begin
    if (push && (wrPtr_reg == rdPtrNext)) begin
      outData_reg <= s.inData;
    end else begin
      outData_reg <= mem[rdPtrNext];
    end
  end
endmodule // mne_fifo
`default_nettype wire

// file: rtl/mne_noise_estimator.sv
// Function
// - Noise bandwidth from slope and time constant
// - Settling taken as 5T/7T/9T/10T
// - Update X and Y every 512 Hz sample
// - Moving mean; deviation is sample minus mean
// - Moving average of deviation magnitudes
// - Fixed gain turns deviation into RMS
// - Averaging length chosen as 16 time constants
// - Normalise by root of noise bandwidth
// - Estimation takes samples only in the idle state and not during a restart
// - Sensitivity change restarts estimate settling
// - Independent X and Y estimators
`timescale 1ns/1ns
`default_nettype none
module mne_noise_estimator (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic signed [15:0]           sampleX,
  input  wire logic signed [15:0]           sampleY,
  input  wire logic                         sampleValid,
  output logic                              sampleReady,
  input  wire logic [3:0]                   tcSel,
  input  wire logic [1:0]                   slopeSel,
  input  wire logic                         sensChange,
  output logic [24:0]                       noiseX,
  output logic [24:0]                       noiseY,
  output logic                              noiseValid,
  output logic                              filterSettled,
  output logic [2:0]                        noiseBwNum,
  output logic [6:0]                        noiseBwDen,
  output logic [3:0]                        waitMult
);
  localparam int SW = mne_pkg::SAMPLE_W;
  localparam int AW = mne_pkg::ACC_W;
  localparam int WW = mne_pkg::WIN_W;
  localparam int DW = mne_pkg::DEV_W;

  mne_stream_if #(.W(mne_pkg::FIFO_W)) blk ();

  mne_fifo #(
    .WIDTH (mne_pkg::FIFO_W),
    .DEPTH (mne_pkg::BLOCKS)
  ) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .s     (blk.fifo)
  );

  mne_pkg::mne_state_t               state_reg;
  mne_pkg::mne_state_t               state_next;
  logic [mne_pkg::TC_W-1:0]          tc_reg;
  logic [1:0]                        slope_reg;
  logic [15:0]                       blkCnt_reg;
  logic [mne_pkg::SETTLE_W-1:0]      settleCnt_reg;
  logic                              noiseValid_reg;
  logic                              filterSettled_reg;
  logic [mne_pkg::FIFO_W-1:0]        hold_reg;
  logic [mne_pkg::NOISE_W-1:0]       noise_reg [2];

  wire signed [SW-1:0]               sampleIn [2];
  wire                               restart;
  wire                               sampleTake;
  wire                               blockEnd;
  wire                               drainFire;
  wire                               loadFire;
  wire [15:0]                        tcLen;
  wire [4:0]                         winShift;
  wire [3:0]                         halfShift;
  wire [15:0]                        kSel;
  wire [mne_pkg::SETTLE_W-1:0]       waitLimit;
  wire [mne_pkg::FIFO_W-1:0]         holdNext;

  assign sampleIn[0] = sampleX;
  assign sampleIn[1] = sampleY;

  // new sensitivity or filter setting restarts
  assign restart    = sensChange || (tcSel != tc_reg) || (slopeSel != slope_reg);
  // strobe accepted whenever idle, unless a restart blocks it
  assign sampleReady = (state_reg == mne_pkg::MNE_IDLE);
  assign sampleTake = sampleValid && sampleReady && !restart;
  // a block spans T samples, 16 blocks form the window
  assign tcLen      = 16'h1 << tc_reg;
  assign blockEnd   = sampleTake && (blkCnt_reg == tcLen - 16'h1);
  // window of 16 T, both averages
  assign winShift   = 5'(mne_pkg::BLOCKS_LOG2) + {1'b0, tc_reg};
  assign halfShift  = 4'(({1'b0, tc_reg} + 5'h1) >> 1);
  // gain carries inverse root bandwidth, odd codes 1/sqrt2
  assign kSel       = tc_reg[0] ? mne_pkg::RMS_K_ODD[slope_reg] : mne_pkg::RMS_K_EVEN[slope_reg];
  // bandwidth fraction per slope, in units of 1/T
  assign noiseBwNum = mne_pkg::NOISE_BW_NUM[slope_reg];
  assign noiseBwDen = mne_pkg::NOISE_BW_DEN[slope_reg];
  // settling multiple of T per slope
  assign waitMult   = mne_pkg::WAIT_MULT[slope_reg];
  assign waitLimit  = {16'h0, waitMult} << tc_reg;

  assign drainFire  = blk.outValid && blk.outReady;
  assign loadFire   = blk.inValid && blk.inReady;
  assign blk.outReady = (state_reg == mne_pkg::MNE_DRAIN);
  assign blk.inValid  = (state_reg == mne_pkg::MNE_LOAD);
  assign blk.inData   = hold_reg;
  assign blk.flush    = restart;

  assign noiseX        = noise_reg[0];
  assign noiseY        = noise_reg[1];
  assign noiseValid    = noiseValid_reg;
  assign filterSettled = filterSettled_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mne_pkg::MNE_IDLE: begin
        if (blockEnd) begin
          state_next = blk.full ? mne_pkg::MNE_DRAIN : mne_pkg::MNE_LOAD;
        end
      end
      mne_pkg::MNE_DRAIN: begin
        if (drainFire) begin
          state_next = mne_pkg::MNE_LOAD;
        end
      end
      mne_pkg::MNE_LOAD: begin
        if (loadFire) begin
          state_next = mne_pkg::MNE_IDLE;
        end
      end
      default: begin
        state_next = mne_pkg::MNE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      state_reg <= mne_pkg::MNE_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tc_reg    <= '0;
      slope_reg <= mne_pkg::SLOPE_12DB;
    end else begin
      tc_reg    <= tcSel;
      slope_reg <= slopeSel;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      blkCnt_reg        <= '0;
      settleCnt_reg     <= '0;
      noiseValid_reg    <= 1'b0;
      filterSettled_reg <= 1'b0;
      hold_reg          <= '0;
    end else begin
      if (sampleTake) begin
        blkCnt_reg <= blockEnd ? 16'h0 : blkCnt_reg + 16'h1;
        if (settleCnt_reg != {mne_pkg::SETTLE_W{1'b1}}) begin
          settleCnt_reg <= settleCnt_reg + 1'b1;
        end
      end
      if (blockEnd) begin
        hold_reg <= holdNext;
      end
      if (blk.full) begin
        noiseValid_reg <= 1'b1;
      end
      // settled once wait time has passed
      filterSettled_reg <= (settleCnt_reg >= waitLimit);
    end
  end

  // one estimator per channel, nothing shared but timing
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic signed [WW-1:0] winSum_reg;
    logic [WW-1:0]        absWin_reg;
    logic signed [AW-1:0] blkSum_reg;
    logic [AW-1:0]        blkAbs_reg;

    wire signed [WW-1:0]  meanWide;
    wire signed [DW-1:0]  dev;
    wire [DW-1:0]         absDev;
    wire signed [AW-1:0]  sumNext;
    wire [AW-1:0]         absNext;
    wire signed [AW-1:0]  popSum;
    wire [AW-1:0]         popAbs;
    wire signed [AW-1:0]  holdSum;
    wire [AW-1:0]         holdAbs;
    wire [WW-1:0]         absAvgWide;
    wire [32:0]           rmsProd;
    wire [40:0]           scaled;

    // mean of window, deviation from it
    assign meanWide = winSum_reg >>> winShift;
    assign dev      = DW'(sampleIn[ch]) - meanWide[DW-1:0];
    // magnitude of deviation feeds the second average
    assign absDev   = dev[DW-1] ? DW'(-dev) : dev;
    assign sumNext  = blkSum_reg + AW'(sampleIn[ch]);
    assign absNext  = blkAbs_reg + AW'(absDev);

    assign popSum   = blk.outData[ch*2*AW +: AW];
    assign popAbs   = blk.outData[ch*2*AW+AW +: AW];
    assign holdSum  = hold_reg[ch*2*AW +: AW];
    assign holdAbs  = hold_reg[ch*2*AW+AW +: AW];
    assign holdNext[ch*2*AW +: 2*AW] = {absNext, sumNext};

    assign absAvgWide = absWin_reg >> winShift;
    // fixed Gaussian factor folded into kSel
    assign rmsProd    = absAvgWide[16:0] * kSel;
    assign scaled     = {8'h0, rmsProd} << halfShift;

    always_ff @(posedge clk) begin
      if (!rst_n || restart) begin
        blkSum_reg <= '0;
        blkAbs_reg <= '0;
      end else if (sampleTake) begin
        blkSum_reg <= blockEnd ? '0 : sumNext;
        blkAbs_reg <= blockEnd ? '0 : absNext;
      end
    end

    // oldest block leaves before the newest enters
    always_ff @(posedge clk) begin
      if (!rst_n || restart) begin
        winSum_reg <= '0;
        absWin_reg <= '0;
      end else if (drainFire) begin
        winSum_reg <= winSum_reg - WW'(popSum);
        absWin_reg <= absWin_reg - WW'(popAbs);
      end else if (loadFire) begin
        winSum_reg <= winSum_reg + WW'(holdSum);
        absWin_reg <= absWin_reg + WW'(holdAbs);
      end
    end

    // output refreshed on every accepted sample
    always_ff @(posedge clk) begin
      if (!rst_n || restart) begin
        noise_reg[ch] <= '0;
      end else if (sampleTake) begin
        noise_reg[ch] <= scaled[40:mne_pkg::K_FRAC];
      end
    end
  end

endmodule // mne_noise_estimator
`default_nettype wire

// file: verification/mne_noise_estimator_sva.sv
`timescale 1ns/1ns
`default_nettype none
module mne_noise_estimator_sva (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic signed [15:0] sampleX,
  input wire logic signed [15:0] sampleY,
  input wire logic               sampleValid,
  input wire logic               sampleReady,
  input wire logic [3:0]         tcSel,
  input wire logic [1:0]         slopeSel,
  input wire logic               sensChange,
  input wire logic [24:0]        noiseX,
  input wire logic [24:0]        noiseY,
  input wire logic               noiseValid,
  input wire logic               filterSettled,
  input wire logic [2:0]         noiseBwNum,
  input wire logic [6:0]         noiseBwDen,
  input wire logic [3:0]         waitMult
);
  logic [3:0] tcPrev_reg;
  logic [1:0] slopePrev_reg;
  wire        restartNow = sensChange || tcSel != tcPrev_reg || slopeSel != slopePrev_reg;
  wire        takeNow    = sampleValid && sampleReady && !restartNow;

  always_ff @(posedge clk) begin
    tcPrev_reg    <= tcSel;
    slopePrev_reg <= slopeSel;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cleared;
    noiseX == 25'h0 && noiseY == 25'h0 && !noiseValid && !filterSettled;
  endsequence
  sequence s_back;
    ##[1:3] sampleReady;
  endsequence

  property p_equiv_noise_bandwidth;
    $past(rst_n) |-> noiseBwNum == mne_pkg::NOISE_BW_NUM[$past(slopeSel)]
      && noiseBwDen == mne_pkg::NOISE_BW_DEN[$past(slopeSel)];
  endproperty
  a_equiv_noise_bandwidth: assert property (p_equiv_noise_bandwidth) else $error("bandwidth code mismatch");
  property p_wait;
    $past(rst_n) |-> waitMult == mne_pkg::WAIT_MULT[$past(slopeSel)];
  endproperty
  a_wait: assert property (p_wait) else $error("wait multiple mismatch");
  property p_restart;
    $past(rst_n) && restartNow |=> s_cleared;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear");
  property p_hold;
    !takeNow && !restartNow |=> $stable(noiseX) && $stable(noiseY);
  endproperty
  a_hold: assert property (p_hold) else $error("noise moved without sample");
  property p_ready;
    !sampleReady |-> s_back;
  endproperty
  a_ready: assert property (p_ready) else $error("ready low too long");
  property p_drop;
    $fell(sampleReady) |-> $past(sampleValid);
  endproperty
  a_drop: assert property (p_drop) else $error("ready fell without sample");
  property p_valid_keep;
    noiseValid && !restartNow |=> noiseValid;
  endproperty
  a_valid_keep: assert property (p_valid_keep) else $error("valid dropped");
  property p_settled_keep;
    filterSettled && !restartNow |=> filterSettled;
  endproperty
  a_settled_keep: assert property (p_settled_keep) else $error("settled dropped");
endmodule // mne_noise_estimator_sva

bind mne_noise_estimator mne_noise_estimator_sva u_sva (
  .clk, .rst_n, .sampleX, .sampleY, .sampleValid, .sampleReady, .tcSel, .slopeSel,
  .sensChange, .noiseX, .noiseY, .noiseValid, .filterSettled, .noiseBwNum, .noiseBwDen,
  .waitMult);
`default_nettype wire

// file: verification/mne_sample_source.sv
`timescale 1ns/1ns
`default_nettype none
module mne_sample_source (
  input  wire logic               clk,
  input  wire logic               enable,
  input  wire logic               alternate,
  input  wire logic signed [15:0] ampX,
  input  wire logic signed [15:0] ampY,
  output logic signed [15:0]      sampleX,
  output logic signed [15:0]      sampleY,
  output logic                    sampleValid
);
  int   count = 0;
  logic phase = 1'b0;

  initial begin
    sampleX = 16'h0;
    sampleY = 16'h0;
    sampleValid = 1'b0;
  end

  always @(posedge clk) begin
    sampleValid <= enable && count == 0;
    count <= (!enable || count == 7) ? 0 : count + 1;
    if (enable && count == 0) begin
      phase   <= ~phase;
      sampleX <= (alternate && phase) ? -ampX : ampX;
      sampleY <= (alternate && phase) ? -ampY : ampY;
    end else begin
      sampleX <= ~sampleX;
      sampleY <= ~sampleY;
    end
  end
endmodule // mne_sample_source
`default_nettype wire

// file: verification/mne_noise_estimator_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mne_noise_estimator_tb;
  typedef struct packed {
    logic [3:0]  tc;
    logic [1:0]  slope;
    logic        alt;
    logic [15:0] amp;
    logic [2:0]  num;
    logic [6:0]  den;
    logic [3:0]  wmul;
  } mne_row_t;
  localparam mne_row_t ROWS [5] = '{
    '{4'h0, 2'h0, 1'b1, 16'h0400, 3'h1, 7'h04, 4'h5},
    '{4'h1, 2'h1, 1'b1, 16'h0200, 3'h1, 7'h08, 4'h7},
    '{4'h2, 2'h2, 1'b1, 16'h0100, 3'h3, 7'h20, 4'h9},
    '{4'h0, 2'h3, 1'b1, 16'h0300, 3'h5, 7'h40, 4'ha},
    '{4'h1, 2'h0, 1'b0, 16'h0500, 3'h1, 7'h04, 4'h5}
  };
  logic               clk        = 1'b0;
  logic               rst_n      = 1'b0;
  logic               en         = 1'b0;
  logic               alt        = 1'b0;
  logic signed [15:0] ampX       = 16'h0;
  logic signed [15:0] ampY       = 16'h0;
  logic [3:0]         tcSel      = 4'h0;
  logic [1:0]         slopeSel   = 2'h1;
  logic               sensChange = 1'b0;
  logic signed [15:0] sampleX, sampleY;
  logic               sampleValid, sampleReady, noiseValid, filterSettled;
  logic [24:0]        noiseX, noiseY;
  logic [2:0]         noiseBwNum;
  logic [6:0]         noiseBwDen;
  logic [3:0]         waitMult;
  int                 miscompares = 0;
  int                 num_checks  = 0;

  mne_sample_source u_src (.clk, .enable(en), .alternate(alt), .ampX, .ampY,
    .sampleX, .sampleY, .sampleValid);
  mne_noise_estimator u_dut (.clk, .rst_n, .sampleX, .sampleY, .sampleValid, .sampleReady,
    .tcSel, .slopeSel, .sensChange, .noiseX, .noiseY, .noiseValid, .filterSettled,
    .noiseBwNum, .noiseBwDen, .waitMult);

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Steady alternating input gives a mean absolute deviation equal to its amplitude
  function automatic logic [31:0] expn(input logic [3:0] tc, input logic [1:0] sl,
                                       input logic [15:0] a);
    logic [63:0] k;
    k = tc[0] ? 64'(mne_pkg::RMS_K_ODD[sl]) : 64'(mne_pkg::RMS_K_EVEN[sl]);
    return 32'(((64'(a) * k) << ((tc + 4'h1) >> 1)) >> 16);
  endfunction

  task automatic wait_samples(input int n);
    repeat (n) begin
      @(posedge clk);
      while (sampleValid !== 1'b1) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic run_row(input mne_row_t r);
    @(posedge clk);
    tcSel    <= r.tc;
    slopeSel <= r.slope;
    alt      <= r.alt;
    ampX     <= r.amp;
    ampY     <= r.amp >> 1;
    repeat (2) @(posedge clk);
    en <= 1'b1;
    repeat (1280) @(posedge clk);
    en <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(noiseX), expn(r.tc, r.slope, r.alt ? r.amp : 16'h0));
    chk(32'(noiseY), expn(r.tc, r.slope, r.alt ? r.amp >> 1 : 16'h0));
    chk(32'(noiseBwNum), 32'(r.num));
    chk(32'(noiseBwDen), 32'(r.den));
    chk(32'(waitMult), 32'(r.wmul));
    chk(32'(noiseValid), 32'h1);
    chk(32'(filterSettled), 32'h1);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk);
    #1;
    chk(32'(noiseX), 32'h0);
    chk(32'(noiseValid), 32'h0);
    chk(32'(sampleReady), 32'h1);
    chk(32'(waitMult), 32'h7);
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) run_row(ROWS[i]);
    // Restart between runs with samples stopped, then settle anew at tc 1 and 6 dB
    @(posedge clk);
    sensChange <= 1'b1;
    @(posedge clk);
    sensChange <= 1'b0;
    en <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'(noiseX), 32'h0);
    chk(32'(noiseValid), 32'h0);
    wait_samples(9);
    chk(32'(filterSettled), 32'h0);
    wait_samples(1);
    chk(32'(filterSettled), 32'h1);
    wait_samples(21);
    chk(32'(noiseValid), 32'h0);
    wait_samples(1);
    chk(32'(noiseValid), 32'h1);
    // Reset in mid-run with samples flowing, then recovery
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(noiseY), 32'h0);
    chk(32'(noiseValid), 32'h0);
    chk(32'(filterSettled), 32'h0);
    chk(32'(sampleReady), 32'h1);
    chk(32'(noiseBwDen), 32'h8);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(32'(noiseBwDen), 32'h4);
    chk(32'(waitMult), 32'h5);
    wait_samples(10);
    chk(32'(filterSettled), 32'h1);
    tally_and_finish();
  end
endmodule // mne_noise_estimator_tb
`default_nettype wire
